// file: radio_packet_framer_test.sv
// self-checking bench for the radio packet framer
// assumes rpf_pkg compiled first and the partner model beside it
`timescale 1ns/100ps
`default_nettype none
module radio_packet_framer_test;
  import rpf_pkg::*;
  logic          sys_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, slow = 1'b0;
  logic          txStart = 1'b0, rxStart = 1'b0, stop = 1'b0, rxBitValid = 1'b0, rxBit = 1'b0;
  rpf_cfg_type   cfg = '0;
  logic          txBit, txBitValid, modReady, memRdEn, memWrEn, busy;
  logic [9:0]    memAddr;
  logic [7:0]    memRdData, memWrData;
  logic [2:0]    receivedLogicalMatch;
  rpf_event_type events;
  int            fail_count = 0, compares = 0, nEnd = 0, nBc = 0, nAddr = 0;
  logic          exp [$];

  rpf_packet_framer dut_u (.sys_clk, .rst_n, .ce, .cfg, .txStart, .rxStart, .stop, .txBit,
    .txBitValid, .modReady, .rxBitValid, .rxBit, .memAddr, .memRdEn, .memRdData, .memWrEn,
    .memWrData, .busy, .receivedLogicalMatch, .events);
  rpf_partner partner_u (.sys_clk, .rst_n, .slow, .txBit, .txBitValid, .modReady, .memAddr,
    .memRdEn, .memRdData, .memWrEn, .memWrData);

  // clock and event counters
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (events.endEv === 1'b1) nEnd++;
    if (events.bitCountEv === 1'b1) nBc++;
    if (events.addressEv === 1'b1) nAddr++;
  end

  task automatic step();
    @(posedge sys_clk);
    #5;
  endtask : step

  task automatic tally_and_finish();
    $display("compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    compares++;
    if (got !== want) begin
      fail_count++;
      $display("MISMATCH at %0t: got %0h expected %0h", $time, got, want);
    end
  endtask : check

  task automatic push(input logic [7:0] v, input logic [3:0] w, input logic msb);
    int i;
    for (i = 0; i < w; i++) exp.push_back(msb ? v[w - 1 - i] : v[i]);
  endtask : push

  // expected preamble and address for the selected logical address
  task automatic head(input rpf_cfg_type c);
    logic [31:0] base;
    logic [7:0]  pre;
    logic [2:0]  s, bal;
    logic        fb;
    int          b;
    s = c.transmitLogicalSelect;
    bal = (c.baseAddressBytes > 3'h4) ? 3'h4 : c.baseAddressBytes;
    base = (s == 3'h0) ? c.baseAddressZero : c.baseAddressOne;
    pre = s[2] ? c.prefixBytesHigh[8*s[1:0]+:8] : c.prefixBytesLow[8*s[1:0]+:8];
    fb = (bal != 3'h0) ? base[8*(4-bal)] : pre[0];
    exp.delete();
    case (c.mode)
      LONG_RANGE_125K_MODE, LONG_RANGE_500K_MODE: repeat (10) push(8'h3C, 4'h8, 1'b0);
      LOWRATE_PAN_MODE: repeat (4) push(8'h00, 4'h8, 1'b0);
      default: repeat ((c.mode == LE_TWO_MEGABIT_MODE) ? 2 : 1)
        push(fb ? 8'h55 : 8'hAA, 4'h8, 1'b0);
    endcase
    for (b = 4 - bal; b < 4; b++) push(base[8*b+:8], 4'h8, 1'b0);
    push(pre, 4'h8, 1'b0);
  endtask : head

  task automatic wait_idle();
    int k;
    for (k = 0; k < 5000 && busy !== 1'b0; k++) step();
    if (busy !== 1'b0) begin
      fail_count++;
      tally_and_finish();
    end
    step(); // let closing pulses and writes land
  endtask : wait_idle

  task automatic run_tx(input rpf_cfg_type c, input int n);
    int i, e0;
    cfg = c;
    e0 = nEnd;
    partner_u.got.delete();
    txStart = 1'b1;
    step();
    txStart = 1'b0;
    step();
    wait_idle();
    check(32'(partner_u.got.size()), 32'(exp.size()));
    check(32'(nEnd - e0), 32'h1);
    for (i = 0; i < n && i < partner_u.got.size(); i++)
      check(32'(partner_u.got[i]), 32'(exp[i]));
  endtask : run_tx

  // one-byte preambles of both polarities, and the all-zero preamble
  task automatic t_short_preamble();
    rpf_cfg_type  c;
    rpf_mode_type m [4] = '{LE_ONE_MEGABIT_MODE, VENDOR_ONE_MEGABIT_MODE,
                            VENDOR_TWO_MEGABIT_MODE, LOWRATE_PAN_MODE};
    int           i;
    for (i = 0; i < 4; i++) begin
      c = '0;
      c.mode = m[i];
      c.baseAddressBytes = 3'h3;
      c.baseAddressZero = i[0] ? 32'h12345700 : 32'h89BED600;
      c.prefixBytesLow = 32'h0000008E;
      head(c);
      run_tx(c, exp.size());
    end
  endtask : t_short_preamble

  // two-byte preamble, all header widths, reversed bit order, add-on, slow modulator
  task automatic t_headers();
    rpf_cfg_type c;
    logic [7:0]  img [8] = '{8'hA5, 8'hC3, 8'h06, 8'h11, 8'h22, 8'h33, 8'h81, 8'h3C};
    int          i, b0;
    c = '0;
    c.mode = LE_TWO_MEGABIT_MODE;
    c.preambleLengthSetting = 1'b1;
    c.baseAddressBytes = 3'h4;
    c.transmitLogicalSelect = 3'h5;
    c.baseAddressOne = 32'hC1D2E3F4;
    c.prefixBytesHigh = 32'h00007B00;
    c.preHeaderWidth = 4'h8;
    c.lengthFieldWidth = 4'h6;
    c.postHeaderWidth = 4'h3;
    c.fieldBitOrder = 1'b1;
    c.maxPayloadBytes = 8'h0A;
    c.staticAddonLength = 8'h02;
    c.bitCountEnable = 1'b1;
    c.bitCountTarget = 16'h0005;
    for (i = 0; i < 8; i++) partner_u.mem[i] = img[i];
    head(c);
    push(8'hA5, 4'h8, 1'b1);
    push(8'hC3, 4'h6, 1'b1);
    push(8'h06, 4'h3, 1'b1);
    for (i = 3; i < 8; i++) push(img[i], 4'h8, 1'b1);
    slow = 1'b1;
    b0 = nBc;
    run_tx(c, exp.size());
    check(32'(nBc - b0), 32'h1);
    slow = 1'b0;
  endtask : t_headers

  // long-range framing with indicator, terminators and a payload capped by the maximum
  task automatic t_long_range();
    rpf_cfg_type c;
    int          i;
    c = '0;
    c.baseAddressBytes = 3'h2;
    c.transmitLogicalSelect = 3'h2;
    c.baseAddressOne = 32'h6A5B0000;
    c.prefixBytesLow = 32'h00C40000;
    c.lengthFieldWidth = 4'h8;
    c.maxPayloadBytes = 8'h01;
    partner_u.mem[0] = 8'h02;
    partner_u.mem[1] = 8'h5A;
    for (i = 0; i < 2; i++) begin
      c.mode = i ? LONG_RANGE_500K_MODE : LONG_RANGE_125K_MODE;
      head(c);
      push(i ? 8'h01 : 8'h00, 4'h2, 1'b0);
      push(8'h00, 4'h3, 1'b0);
      push(8'h02, 4'h8, 1'b0);
      push(8'h5A, 4'h8, 1'b0);
      push(8'h00, 4'h3, 1'b0);
      run_tx(c, exp.size());
    end
  endtask : t_long_range

  // receive on logical address 2 with two addresses enabled
  task automatic t_receive();
    rpf_cfg_type c;
    int          i, a0;
    c = '0;
    c.baseAddressBytes = 3'h3;
    c.baseAddressOne = 32'h44332200;
    c.prefixBytesLow = 32'h00990000;
    c.receiveLogicalEnables = 8'h24;
    c.transmitLogicalSelect = 3'h2;
    c.lengthFieldWidth = 4'h8;
    c.maxPayloadBytes = 8'h0A;
    cfg = c;
    for (i = 0; i < 3; i++) partner_u.mem[i] = 8'hFF;
    head(c);
    push(8'h02, 4'h8, 1'b0);
    push(8'h5A, 4'h8, 1'b0);
    push(8'hC7, 4'h8, 1'b0);
    a0 = nAddr;
    rxStart = 1'b1;
    step();
    rxStart = 1'b0;
    for (i = 0; i < exp.size(); i++) begin
      rxBit = exp[i];
      rxBitValid = 1'b1;
      step();
      rxBitValid = 1'b0;
      rxBit = ~rxBit;
      step();
    end
    wait_idle();
    check(32'(nAddr - a0), 32'h1);
    check(32'(receivedLogicalMatch), 32'h2);
    check(32'(partner_u.mem[0]), 32'h02);
    check(32'(partner_u.mem[1]), 32'h5A);
    check(32'(partner_u.mem[2]), 32'hC7);
    rxStart = 1'b1;
    step();
    rxStart = 1'b0;
    stop = 1'b1;
    step();
    stop = 1'b0;
    check(32'(busy), 32'h0);
  endtask : t_receive

  // reset, then the scenarios in turn
  initial begin
    repeat (3) @(posedge sys_clk);
    #5;
    rst_n = 1'b1;
    step();
    t_short_preamble();
    t_headers();
    t_long_range();
    t_receive();
    tally_and_finish();
  end
endmodule : radio_packet_framer_test
`default_nettype wire

// file: rpf_checker_assertions.sv
// concurrent checks on the packet framer ports
// assumes a single sys_clk domain and a bind onto rpf_packet_framer
`timescale 1ns/100ps
`default_nettype none
module rpf_checker
  import rpf_pkg::*;
(
  input wire logic                   sys_clk,
  input wire logic                   rst_n,
  input wire logic                   ce,
  input wire rpf_pkg::rpf_cfg_type   cfg,
  input wire logic                   txStart,
  input wire logic                   rxStart,
  input wire logic                   stop,
  input wire logic                   txBit,
  input wire logic                   txBitValid,
  input wire logic                   modReady,
  input wire logic                   rxBitValid,
  input wire logic                   rxBit,
  input wire logic [9:0]             memAddr,
  input wire logic                   memRdEn,
  input wire logic [7:0]             memRdData,
  input wire logic                   memWrEn,
  input wire logic [7:0]             memWrData,
  input wire logic                   busy,
  input wire logic [2:0]             receivedLogicalMatch,
  input wire rpf_pkg::rpf_event_type events
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // start, handshake, pulse and match relations
  a_start_busy: assert property (ce && txStart |=> busy) else $error("no busy");
  a_first_bit: assert property (ce && txStart |-> ##[1:3] txBitValid) else $error("no bit");
  a_bit_stands: assert property (txBitValid && !modReady && !txStart && !stop
    |=> txBitValid && $stable(txBit)) else $error("bit dropped");
  a_idle_silent: assert property (!busy |-> !txBitValid) else $error("bit while idle");
  a_read_pulse: assert property (memRdEn |=> !memRdEn) else $error("long read");
  a_write_pulse: assert property (memWrEn |=> !memWrEn) else $error("long write");
  a_end_idle: assert property (events.endEv |-> ##[0:1] !busy) else $error("busy at end");
  a_crc_single: assert property (events.crcOkEv |-> !events.crcErrorEv) else $error("crc");
  a_match_enabled: assert property (events.addressEv && $past(rxBitValid)
    |-> ##[0:1] cfg.receiveLogicalEnables[receivedLogicalMatch]) else $error("bad match");
  a_count_pulse: assert property (events.bitCountEv |=> !events.bitCountEv) else $error("cnt");
endmodule : rpf_checker

bind rpf_packet_framer rpf_checker chk_u (.sys_clk, .rst_n, .ce, .cfg, .txStart, .rxStart,
  .stop, .txBit, .txBitValid, .modReady, .rxBitValid, .rxBit, .memAddr, .memRdEn, .memRdData,
  .memWrEn, .memWrData, .busy, .receivedLogicalMatch, .events);
`default_nettype wire

// file: rpf_defines.svh
// constants for the radio packet framer: preamble patterns, field sizes
// assumes inclusion by the framer module only
`ifndef RPF_DEFINES_SVH
`define RPF_DEFINES_SVH
`define RPF_PRE_ZERO_FIRST 8'hAA
`define RPF_PRE_ONE_FIRST 8'h55
`define RPF_PRE_LR 8'h3C
`define RPF_PRE_LR_BYTES 9'h00A
`define RPF_PRE_PAN 8'h00
`define RPF_PRE_PAN_BYTES 9'h004
`define RPF_HDR_PAY_MAX 10'h102
`define RPF_CI_BITS 4'h2
`define RPF_TERM_BITS 4'h3
`define RPF_BASE_BYTES_MAX 3'h4
`define RPF_CI_125K 2'h0
`define RPF_CI_500K 2'h1
`define RPF_WHITE_TAP 7'h10
`endif

// file: rpf_packet_framer.sv
// radio packet framer: serialises a stored packet to the modulator and
// rebuilds received packets into memory
// assumes modulator, demodulator and packet memory run on sys_clk;
// memory read data is valid the cycle after memRdEn is seen high
`timescale 1ns/100ps
`default_nettype none
`include "rpf_defines.svh"

// Behaviour
// - fields go out in fixed order
// - long range adds indicator and terminators
// - static add-on between payload and CRC
// - preamble goes out LSB first
// - one-byte preamble AA or 55 by address
// - two-byte preamble AAAA or 5555
// - long range preamble ten 3C bytes
// - lowrate preamble four zero bytes
// - memory holds headers, length, payload, add-on
// - address, payload LSByte first; CRC MSByte first
// - address bits LSB first, CRC MSB first
// - headers, length, payload bit order selectable
// - field widths configurable, low bits used
// - zero width absent, else one byte
// - headers, length, payload capped 258 bytes
// - address is base plus prefix byte
// - short base drops least significant bytes
// - address selection uses logical numbers 0-7
// - logical address to base/prefix mapping
// - bit counter raises event at target
// - scrambler D7+D4+1 after address
// - serial CRC except preamble, CI and terminators, address optional
module rpf_packet_framer
  import rpf_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  input  wire rpf_pkg::rpf_cfg_type cfg,
  input  wire logic                 txStart,
  input  wire logic                 rxStart,
  input  wire logic                 stop,
  output logic                      txBit,
  output logic                      txBitValid,
  input  wire logic                 modReady,
  input  wire logic                 rxBitValid,
  input  wire logic                 rxBit,
  output logic [9:0]                memAddr,
  output logic                      memRdEn,
  input  wire logic [7:0]           memRdData,
  output logic                      memWrEn,
  output logic [7:0]                memWrData,
  output logic                      busy,
  output logic [2:0]                receivedLogicalMatch,
  output rpf_pkg::rpf_event_type    events
);
  import rpf_pkg::*;

  rpf_state_type st_reg;
  rpf_state_type st_next;

  function automatic logic isLr(input rpf_cfg_type c);
    return c.mode == LONG_RANGE_125K_MODE || c.mode == LONG_RANGE_500K_MODE;
  endfunction : isLr

  function automatic logic isMem(input rpf_field_type f);
    return f inside {F_S0, F_LEN, F_S1, F_PAY, F_ADDON};
  endfunction : isMem

  // base trimmed from the low end, prefix on top, sent from bit 0
  function automatic logic [39:0] addrWord(input rpf_cfg_type c,
                                           input logic [2:0] idx);
    logic [31:0] base;
    logic [7:0]  pre;
    logic [2:0]  bl;
    base = (idx == 3'h0) ? c.baseAddressZero : c.baseAddressOne;
    pre  = idx[2] ? c.prefixBytesHigh[8*idx[1:0] +: 8]
                  : c.prefixBytesLow[8*idx[1:0] +: 8];
    bl   = (c.baseAddressBytes > `RPF_BASE_BYTES_MAX) ? `RPF_BASE_BYTES_MAX
                                                      : c.baseAddressBytes;
    return {pre, base} >> (8 * (4 - bl));
  endfunction : addrWord

  function automatic logic [3:0] bitsPerByte(input rpf_field_type f,
                                             input rpf_cfg_type c);
    unique case (f)
      F_CI:             return `RPF_CI_BITS;
      F_FIRST_TERMINATOR, F_SECOND_TERMINATOR: return `RPF_TERM_BITS;
      F_S0:             return c.preHeaderWidth;
      F_LEN:            return c.lengthFieldWidth;
      F_S1:             return c.postHeaderWidth;
      default:          return 4'h8;
    endcase
  endfunction : bitsPerByte

  function automatic logic [8:0] byteCount(input rpf_field_type f,
                                           input rpf_cfg_type c,
                                           input logic [8:0] pay);
    unique case (f)
      F_PRE: begin
        if (isLr(c)) return `RPF_PRE_LR_BYTES;
        if (c.mode == LOWRATE_PAN_MODE) return `RPF_PRE_PAN_BYTES;
        return c.preambleLengthSetting ? 9'h002 : 9'h001;
      end
      F_ADDR: begin
        if (c.baseAddressBytes > `RPF_BASE_BYTES_MAX) return 9'h005;
        return 9'(c.baseAddressBytes) + 9'h001;
      end
      F_CI, F_FIRST_TERMINATOR, F_SECOND_TERMINATOR: return isLr(c) ? 9'h001 : 9'h000;
      F_S0:    return (c.preHeaderWidth != 4'h0) ? 9'h001 : 9'h000;
      F_LEN:   return (c.lengthFieldWidth != 4'h0) ? 9'h001 : 9'h000;
      F_S1:    return (c.postHeaderWidth != 4'h0) ? 9'h001 : 9'h000;
      F_PAY:   return pay;
      F_ADDON: return 9'(c.staticAddonLength);
      F_CRC:   return 9'(c.crcBytes);
      default: return 9'h000;
    endcase
  endfunction : byteCount

  // next field with a nonzero size, idle after the last
  function automatic rpf_field_type nextField(input rpf_field_type f,
                                              input rpf_cfg_type c,
                                              input logic [8:0] pay);
    rpf_field_type n;
    logic          done;
    n    = f;
    done = 1'b0;
    for (int i = 0; i < 12; i++) begin
      if (!done) begin
        n    = n.next();
        done = (n == F_IDLE) || (byteCount(n, c, pay) != 9'h000);
      end
    end
    return n;
  endfunction : nextField

  // bit position inside a stored byte for the selected order
  function automatic logic [2:0] bitPos(input logic [2:0] idx,
                                        input logic [3:0] w,
                                        input logic big);
    return big ? 3'(w - 4'h1 - {1'b0, idx}) : idx;
  endfunction : bitPos

  function automatic logic [23:0] crcStep(input logic [23:0] crc,
                                          input logic b,
                                          input rpf_cfg_type c);
    logic [4:0]  msb;
    logic [23:0] n;
    msb = 5'(8 * c.crcBytes - 1);
    n   = {crc[22:0], 1'b0} ^ ((crc[msb] ^ b) ? c.crcPoly : 24'h000000);
    return n & 24'((25'h0000001 << (8 * c.crcBytes)) - 25'h0000001);
  endfunction : crcStep

  function automatic logic [8:0] payCap(input logic [7:0] v,
                                        input rpf_cfg_type c);
    logic [8:0] p;
    logic [9:0] lim;
    p   = {1'b0, v & 8'((9'h001 << c.lengthFieldWidth) - 9'h001)};
    if (p > {1'b0, c.maxPayloadBytes}) p = {1'b0, c.maxPayloadBytes};
    lim = `RPF_HDR_PAY_MAX - 10'(c.preHeaderWidth != 4'h0)
        - 10'(c.lengthFieldWidth != 4'h0) - 10'(c.postHeaderWidth != 4'h0);
    if ({1'b0, p} > lim) p = lim[8:0];
    return p;
  endfunction : payCap

  // datapath terms of the present field and bit
  logic [39:0] addrTx;
  logic [7:0]  preByte;
  logic [3:0]  bpb;
  logic [8:0]  cnt;
  logic [2:0]  pos;
  logic [4:0]  crcIdx;
  logic        rawBit;
  logic        wBit;
  logic        inCrc;
  logic [1:0]  ciVal;

  assign addrTx = addrWord(cfg, cfg.transmitLogicalSelect);
  assign bpb    = bitsPerByte(st_reg.field, cfg);
  assign cnt    = byteCount(st_reg.field, cfg, st_reg.payBytes);
  assign pos    = bitPos(st_reg.bitIdx, bpb, cfg.fieldBitOrder);
  assign crcIdx = 5'(8 * cfg.crcBytes - 1 - 8 * st_reg.byteIdx[1:0]
                  - st_reg.bitIdx);
  assign ciVal  = (cfg.mode == LONG_RANGE_500K_MODE) ? `RPF_CI_500K
                                                     : `RPF_CI_125K;
  assign wBit   = cfg.scramblerEnable && st_reg.field > F_ADDR
                  && st_reg.white[6];
  assign inCrc  = isMem(st_reg.field)
                  || (st_reg.field == F_ADDR && !cfg.crcSkipAddress);

  // preamble pattern: fixed for long range and lowrate, else follows the first address bit
  always_comb begin
    if (isLr(cfg)) preByte = `RPF_PRE_LR;
    else if (cfg.mode == LOWRATE_PAN_MODE) preByte = `RPF_PRE_PAN;
    else preByte = addrTx[0] ? `RPF_PRE_ONE_FIRST
                             : `RPF_PRE_ZERO_FIRST;
  end

  // unscrambled bit to send now
  always_comb begin
    unique case (st_reg.field)
      F_PRE:  rawBit = preByte[st_reg.bitIdx];
      F_ADDR: rawBit = addrTx[6'({st_reg.byteIdx[2:0], st_reg.bitIdx})];
      F_CI:   rawBit = ciVal[st_reg.bitIdx[0]];
      F_CRC:  rawBit = st_reg.crc[crcIdx];
      F_S0, F_LEN, F_S1, F_PAY, F_ADDON: rawBit = st_reg.curByte[pos];
      default: rawBit = 1'b0;
    endcase
  end

  // framing sequencer: next state
  always_comb begin
    logic          step;
    logic          b;
    logic          lastBit;
    logic [7:0]    nb;
    logic [8:0]    payNow;
    logic [39:0]   sh;
    logic [39:0]   aw;
    logic [5:0]    abits;
    logic          hit;
    logic [2:0]    hitIdx;
    rpf_field_type nf;
    step    = st_reg.txMode ? (st_reg.txValid && modReady) : rxBitValid;
    b       = st_reg.txMode ? rawBit : (rxBit ^ wBit);
    lastBit = {1'b0, st_reg.bitIdx} == bpb - 4'h1;
    nb      = st_reg.curByte;
    nb[pos] = b;
    payNow  = st_reg.payBytes;
    sh      = {rxBit, st_reg.rxShift[39:1]};
    abits   = 6'(8 * byteCount(F_ADDR, cfg, 9'h000));
    hit     = 1'b0;
    hitIdx  = 3'h0;
    aw      = '0;
    nf      = st_reg.field;
    st_next = st_reg;
    st_next.ev      = '0;
    st_next.memRdEn = 1'b0;
    st_next.memWrEn = 1'b0;
    if (txStart || rxStart) begin
      st_next         = '0;
      st_next.txMode  = txStart;
      st_next.field   = txStart ? F_PRE : F_ADDR;
      st_next.prep    = txStart;
      st_next.crc     = cfg.crcInit;
      st_next.white   = cfg.scramblerInit;
      st_next.payBytes = {1'b0, cfg.maxPayloadBytes};
      st_next.memAddr = txStart ? 10'h000 : 10'h3FF;
    end else if (stop) begin
      st_next.field   = F_IDLE;
      st_next.txValid = 1'b0;
    end else if (st_reg.field != F_IDLE) begin
      if (st_reg.fetch == 2'h2) begin
        st_next.fetch = 2'h1;
      end else if (st_reg.fetch == 2'h1) begin
        st_next.curByte = memRdData;
        st_next.fetch   = 2'h0;
        st_next.prep    = 1'b1;
        if (st_reg.field == F_LEN)
          st_next.payBytes = payCap(memRdData, cfg);
      end else if (st_reg.prep) begin
        st_next.txBit   = rawBit ^ wBit;
        st_next.txValid = 1'b1;
        st_next.prep    = 1'b0;
      end else if (step && !st_reg.txMode && st_reg.field == F_ADDR) begin
        // address search over the last received bits
        st_next.rxShift = sh;
        if (st_reg.searchCnt != 6'h3F)
          st_next.searchCnt = st_reg.searchCnt + 6'h01;
        for (int i = 7; i >= 0; i--) begin
          if (cfg.receiveLogicalEnables[i] && st_next.searchCnt >= abits
              && (sh >> (6'd40 - abits)) == addrWord(cfg, 3'(i))) begin
            hit    = 1'b1;
            hitIdx = 3'(i);
          end
        end
        if (hit) begin
          aw = addrWord(cfg, hitIdx);
          if (!cfg.crcSkipAddress) begin
            for (int k = 0; k < 40; k++) begin
              if (6'(k) < abits)
                st_next.crc = crcStep(st_next.crc, aw[k], cfg);
            end
          end
          st_next.match        = hitIdx;
          st_next.ev.addressEv = 1'b1;
          st_next.field        = nextField(F_ADDR, cfg, st_reg.payBytes);
        end
      end else if (step) begin
        st_next.txValid = 1'b0;
        if (inCrc)
          st_next.crc = crcStep(st_reg.crc, b, cfg);
        if (st_reg.field == F_CRC && !st_reg.txMode && b != st_reg.crc[crcIdx])
          st_next.crcBad = 1'b1;
        if (cfg.scramblerEnable && st_reg.field > F_ADDR)
          st_next.white = {st_reg.white[5:0], st_reg.white[6]}
                          ^ (st_reg.white[6] ? `RPF_WHITE_TAP : 7'h00);
        if (st_reg.field > F_ADDR) begin
          st_next.bitCnt = st_reg.bitCnt + 16'h0001;
          if (cfg.bitCountEnable && st_next.bitCnt == cfg.bitCountTarget)
            st_next.ev.bitCountEv = 1'b1;
        end
        if (!st_reg.txMode && isMem(st_reg.field))
          st_next.curByte = nb;
        if (!lastBit) begin
          st_next.bitIdx = st_reg.bitIdx + 3'h1;
          st_next.prep   = st_reg.txMode;
        end else begin
          st_next.bitIdx = 3'h0;
          if (!st_reg.txMode && isMem(st_reg.field)) begin
            st_next.memWrEn   = 1'b1;
            st_next.memWrData = nb;
            st_next.memAddr   = st_reg.memAddr + 10'h001;
            if (st_reg.field == F_LEN) begin
              payNow           = payCap(nb, cfg);
              st_next.payBytes = payNow;
            end
          end
          if (st_reg.byteIdx != cnt - 9'h001) begin
            st_next.byteIdx = st_reg.byteIdx + 9'h001;
          end else begin
            st_next.byteIdx = 9'h000;
            nf              = nextField(st_reg.field, cfg, payNow);
            st_next.field   = nf;
            if (st_reg.field == F_ADDR) st_next.ev.addressEv = 1'b1;
            if (st_reg.field == F_PAY) st_next.ev.payloadEv = 1'b1;
            if (nf == F_IDLE) begin
              st_next.ev.endEv = 1'b1;
              if (!st_reg.txMode && cfg.crcBytes != 2'h0) begin
                st_next.ev.crcOkEv    = !st_next.crcBad;
                st_next.ev.crcErrorEv = st_next.crcBad;
              end
            end
          end
          if (st_reg.txMode && st_next.field != F_IDLE) begin
            if (isMem(st_next.field)) begin
              st_next.memRdEn = 1'b1;
              st_next.fetch   = 2'h2;
              if (st_reg.field != F_PRE && st_reg.field != F_IDLE
                  && isMem(st_reg.field))
                st_next.memAddr = st_reg.memAddr + 10'h001;
            end else begin
              st_next.prep = 1'b1;
            end
          end
        end
      end
    end
  end

  // framing sequencer: registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state registers
  assign txBit                = st_reg.txBit;
  assign txBitValid           = st_reg.txValid;
  assign memAddr              = st_reg.memAddr;
  assign memRdEn              = st_reg.memRdEn;
  assign memWrEn              = st_reg.memWrEn;
  assign memWrData            = st_reg.memWrData;
  assign busy                 = st_reg.field != F_IDLE;
  assign receivedLogicalMatch = st_reg.match;
  assign events               = st_reg.ev;
endmodule : rpf_packet_framer
`default_nettype wire

// file: rpf_partner.sv
// modulator and packet memory standing at the framer's far side
// assumes sys_clk shared with the framer; read data one cycle after memRdEn
`timescale 1ns/100ps
`default_nettype none
module rpf_partner (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       slow,
  input  wire logic       txBit,
  input  wire logic       txBitValid,
  output logic            modReady,
  input  wire logic [9:0] memAddr,
  input  wire logic       memRdEn,
  output logic [7:0]      memRdData,
  input  wire logic       memWrEn,
  input  wire logic [7:0] memWrData
);
  logic [7:0] mem [0:1023];
  logic       got [$];
  logic [1:0] pace;
  // ready every cycle, or one cycle in three when slow
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) pace <= 2'h0;
    else pace <= (pace == 2'h2) ? 2'h0 : pace + 2'h1;
  end
  assign modReady = !slow || (pace == 2'h0);
  // collect taken bits, serve reads, store writes
  always @(posedge sys_clk) begin
    if (txBitValid && modReady) got.push_back(txBit);
    if (memWrEn) mem[memAddr] = memWrData;
    if (memRdEn) memRdData <= mem[memAddr];
    else memRdData <= ~memRdData; // stale data never looks valid
  end
endmodule : rpf_partner
`default_nettype wire

// file: rpf_pkg.sv
// types shared by the radio packet framer
// assumes nothing beyond a SystemVerilog compiler
package rpf_pkg;
  typedef enum logic [2:0] {
    LE_ONE_MEGABIT_MODE, LE_TWO_MEGABIT_MODE, VENDOR_ONE_MEGABIT_MODE,
    VENDOR_TWO_MEGABIT_MODE, LONG_RANGE_125K_MODE, LONG_RANGE_500K_MODE,
    LOWRATE_PAN_MODE
  } rpf_mode_type;

  // on-air fields in send order
  typedef enum logic [3:0] {
    F_IDLE, F_PRE, F_ADDR, F_CI, F_FIRST_TERMINATOR, F_S0, F_LEN, F_S1,
    F_PAY, F_ADDON, F_CRC, F_SECOND_TERMINATOR
  } rpf_field_type;

  typedef struct packed {
    rpf_mode_type mode;
    logic         preambleLengthSetting;
    logic [3:0]   preHeaderWidth;
    logic [3:0]   lengthFieldWidth;
    logic [3:0]   postHeaderWidth;
    logic         fieldBitOrder;
    logic [7:0]   staticAddonLength;
    logic [7:0]   maxPayloadBytes;
    logic [2:0]   baseAddressBytes;
    logic         scramblerEnable;
    logic [6:0]   scramblerInit;
    logic [1:0]   crcBytes;
    logic         crcSkipAddress;
    logic [23:0]  crcPoly;
    logic [23:0]  crcInit;
    logic [31:0]  baseAddressZero;
    logic [31:0]  baseAddressOne;
    logic [31:0]  prefixBytesLow;
    logic [31:0]  prefixBytesHigh;
    logic [2:0]   transmitLogicalSelect;
    logic [7:0]   receiveLogicalEnables;
    logic         bitCountEnable;
    logic [15:0]  bitCountTarget;
  } rpf_cfg_type;

  typedef struct packed {
    logic addressEv;
    logic payloadEv;
    logic endEv;
    logic bitCountEv;
    logic crcOkEv;
    logic crcErrorEv;
  } rpf_event_type;

  typedef struct packed {
    rpf_field_type field;
    logic          txMode;
    logic [8:0]    byteIdx;
    logic [2:0]    bitIdx;
    logic [7:0]    curByte;
    logic [8:0]    payBytes;
    logic [23:0]   crc;
    logic [6:0]    white;
    logic          crcBad;
    logic [15:0]   bitCnt;
    logic [1:0]    fetch;
    logic          prep;
    logic          txValid;
    logic          txBit;
    logic [39:0]   rxShift;
    logic [5:0]    searchCnt;
    logic [2:0]    match;
    logic [9:0]    memAddr;
    logic          memRdEn;
    logic          memWrEn;
    logic [7:0]    memWrData;
    rpf_event_type ev;
  } rpf_state_type;
endpackage : rpf_pkg
